// ===== core/fpcsr_regs.sv
// Floating-point control and status register bank with alias views
// How it works
// R01: Reset value enables all five exceptions.
// R02: Compare writes its outcome to condition bit.
// R03: Flush mode turns denormal results into zero.
// R04: Bit 21 enables stack-top register renaming.
// R05: Cause field sits in bits 17 to 12.
// R06: Several conditions set several cause bits together.
// R07: Operations and control writes to main or exception view rewrite cause; moves leave it.
// R08: Unimplemented cause set when emulation needed.
// R09: Trapping operation writes no destination result.
// R10: Cause with its enable raises exception immediately.
// R11: Unimplemented cause always raises an exception.
// R12: Handler clears enabled cause before returning.
// R13: Untrapped operation writes default result, no exception.
// R14: Flags sticky, cleared only by control write.
// R15: Trapping operation leaves flags untouched.
// R16: Two low bits select rounding for operations.
// R17: Mode zero rounds nearest, ties to even.
// R18: Mode three rounds toward negative infinity.
// R19: Condition alias packs the eight condition bits.
// R20: Exception alias shows cause and flags only.
// R21: Enable alias shows enables, flush, rounding.
// R22: Mode one toward zero, two toward plus.
// R23: Fields placed in the customary bit layout.
`timescale 1ns/1ps
module fpcsr_regs (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Control-move access
    input  wire logic        ctl_wr_en,
    input  wire logic        ctl_rd_en,
    input  wire logic [4:0]  ctl_addr,
    input  wire logic [31:0] ctl_wdata,
    output logic      [31:0] ctl_rdata,
    // Compare results
    input  wire logic        cmp_valid,
    input  wire logic [2:0]  cmp_cc_index,
    input  wire logic        cmp_result,
    // Completing arithmetic operation
    input  wire logic        op_valid,
    input  wire logic [5:0]  op_exc,
    input  wire logic        op_denorm,
    output logic             result_wr_en,
    output logic             result_force_zero,
    output logic             fp_exc_trap,
    // Rounding request from the datapath
    input  wire logic        rnd_valid,
    input  wire logic        rnd_sign,
    input  wire logic        rnd_lsb,
    input  wire logic        rnd_guard,
    input  wire logic        rnd_sticky,
    output logic             rnd_inc_valid,
    output logic             rnd_increment,
    // Register renaming for decode
    input  wire logic [4:0]  rename_in,
    input  wire logic [2:0]  stack_top,
    output logic      [4:0]  rename_out,
    // Live control fields
    output logic      [1:0]  rounding_field,
    output logic             flush_to_zero,
    output logic             stack_top_mode,
    output logic      [7:0]  fp_condition_codes
);
    logic [7:0] fcc;
    logic       ftz;
    logic       top_mode;
    logic [5:0] cause;
    logic [4:0] enables;
    logic [4:0] flags;
    logic [1:0] rm;

    // Address decode
    wire hit_main = (ctl_addr == fpcsr_pkg::ADDR_CTRL_STATUS);
    wire hit_cond = (ctl_addr == fpcsr_pkg::ADDR_COND_ALIAS);
    wire hit_exc  = (ctl_addr == fpcsr_pkg::ADDR_EXC_ALIAS);
    wire hit_en   = (ctl_addr == fpcsr_pkg::ADDR_EN_ALIAS);
    wire wr_main  = clk_en & ctl_wr_en & hit_main;
    wire wr_cond  = clk_en & ctl_wr_en & hit_cond;
    wire wr_exc   = clk_en & ctl_wr_en & hit_exc;
    wire wr_en    = clk_en & ctl_wr_en & hit_en;

    // Main and alias views
    wire [31:0] view_main = {fcc[7:1], ftz, fcc[0], 1'b0, top_mode, 3'b000,
                             cause, enables, flags, rm};  // see R05 see R23
    wire [31:0] view_cond = {24'h00_0000, fcc};  // see R19
    wire [31:0] view_exc  = {14'h0000, cause, 5'h00, flags, 2'b00};  // see R20
    wire [31:0] view_en   = {20'h0_0000, enables, 4'h0, ftz, rm};  // see R21
    wire [31:0] read_sel  = hit_main ? view_main :
                            hit_cond ? view_cond :
                            hit_exc  ? view_exc  :
                            hit_en   ? view_en   : 32'h0000_0000;

    // Write data per alias
    wire [5:0] w_cause  = ctl_wdata[fpcsr_pkg::CAUSE_MSB:fpcsr_pkg::CAUSE_LSB];
    wire [4:0] w_enable = ctl_wdata[fpcsr_pkg::ENABLE_MSB:fpcsr_pkg::ENABLE_LSB];
    wire [4:0] w_flag   = ctl_wdata[fpcsr_pkg::FLAG_MSB:fpcsr_pkg::FLAG_LSB];
    wire [1:0] w_rm     = ctl_wdata[fpcsr_pkg::RM_MSB:fpcsr_pkg::RM_LSB];
    wire [7:0] w_fcc_main = {ctl_wdata[fpcsr_pkg::FCC_HI_MSB:fpcsr_pkg::FCC_HI_LSB],
                             ctl_wdata[fpcsr_pkg::FCC0_BIT]};

    // Operation evaluation
    logic [5:0] eff_cause;
    logic       op_traps;
    logic       flush_zero;

    fpcsr_exc_eval u_exc_eval (
        .raw_exc       (op_exc),
        .denorm_result (op_denorm),
        .flush_en      (ftz),
        .enables       (enables),
        .eff_cause     (eff_cause),
        .flush_zero    (flush_zero),
        .traps         (op_traps)
    );

    wire op_fire = clk_en & op_valid;
    assign result_wr_en      = op_valid & ~op_traps;  // see R09 see R13
    assign result_force_zero = op_valid & flush_zero;  // see R03
    // Live trap from stored cause, also after control writes
    assign fp_exc_trap = (|(cause[4:0] & enables))
                       | cause[fpcsr_pkg::EXC_UNIMPL];  // see R10 see R11 see R12

    // Next values
    wire [7:0] fcc_base   = wr_main ? w_fcc_main : wr_cond ? ctl_wdata[7:0] : fcc;
    wire [7:0] cmp_mask   = 8'h01 << cmp_cc_index;
    wire       cmp_fire   = clk_en & cmp_valid;
    wire [7:0] next_fcc   = cmp_fire ? ((fcc_base & ~cmp_mask)
                                       | (cmp_result ? cmp_mask : 8'h00))
                                     : fcc_base;  // see R02
    wire [5:0] cause_base = (wr_main | wr_exc) ? w_cause : cause;
    wire [5:0] next_cause = op_fire ? eff_cause : cause_base;  // see R07
    wire [4:0] flag_base  = (wr_main | wr_exc) ? w_flag : flags;
    wire [4:0] flag_set   = (op_fire & ~op_traps) ? eff_cause[4:0] : 5'h00;
    wire [4:0] next_flags = flag_base | flag_set;  // see R14 see R15
    wire [4:0] next_enables = (wr_main | wr_en) ? w_enable : enables;
    wire       next_ftz   = wr_main ? ctl_wdata[fpcsr_pkg::FTZ_BIT] :
                            wr_en   ? ctl_wdata[fpcsr_pkg::EN_ALIAS_FTZ_BIT] : ftz;
    wire [1:0] next_rm    = (wr_main | wr_en) ? w_rm : rm;
    wire       next_top   = wr_main ? ctl_wdata[fpcsr_pkg::TOP_MODE_BIT] : top_mode;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fcc      <= 8'h00;
            ftz      <= fpcsr_pkg::CTRL_STATUS_RESET[fpcsr_pkg::FTZ_BIT];
            top_mode <= fpcsr_pkg::CTRL_STATUS_RESET[fpcsr_pkg::TOP_MODE_BIT];
            cause    <= fpcsr_pkg::CTRL_STATUS_RESET[fpcsr_pkg::CAUSE_MSB:fpcsr_pkg::CAUSE_LSB];
            enables  <= fpcsr_pkg::CTRL_STATUS_RESET[fpcsr_pkg::ENABLE_MSB:
                                                     fpcsr_pkg::ENABLE_LSB];  // see R01
            flags    <= fpcsr_pkg::CTRL_STATUS_RESET[fpcsr_pkg::FLAG_MSB:fpcsr_pkg::FLAG_LSB];
            rm       <= fpcsr_pkg::CTRL_STATUS_RESET[fpcsr_pkg::RM_MSB:fpcsr_pkg::RM_LSB];
        end else begin
            fcc      <= next_fcc;
            ftz      <= next_ftz;
            top_mode <= next_top;
            cause    <= next_cause;
            enables  <= next_enables;
            flags    <= next_flags;
            rm       <= next_rm;
        end
    end

    // Registered read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_rdata <= 32'h0000_0000;
        end else if (clk_en && ctl_rd_en) begin
            ctl_rdata <= read_sel;
        end
    end

    // Rounding decision, one cycle after request
    logic rnd_inc_comb;

    fpcsr_round_decide u_round (
        .mode      (rm),
        .sign      (rnd_sign),
        .lsb       (rnd_lsb),
        .guard     (rnd_guard),
        .sticky    (rnd_sticky),
        .increment (rnd_inc_comb)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rnd_inc_valid <= 1'b0;
            rnd_increment <= 1'b0;
        end else if (clk_en) begin
            rnd_inc_valid <= rnd_valid;
            rnd_increment <= rnd_valid & rnd_inc_comb;  // see R16
        end
    end

    // Stack-top renaming of the low register bits
    wire [2:0] renamed_low = rename_in[2:0] + stack_top;
    assign rename_out = top_mode ? {rename_in[4:3], renamed_low} : rename_in;  // see R04

    assign rounding_field     = rm;
    assign flush_to_zero      = ftz;
    assign stack_top_mode     = top_mode;
    assign fp_condition_codes = fcc;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_trap_op;
        clk_en && op_valid && op_traps;
    endsequence

    sequence s_quiet_op;
        clk_en && op_valid && !op_traps && !ctl_wr_en;
    endsequence

    property p_compare_writes;
        clk_en && cmp_valid |=> fcc[$past(cmp_cc_index)] == $past(cmp_result);
    endproperty
    a_compare_writes: assert property (p_compare_writes) else $error("compare bit wrong"); // see R02

    property p_flush_zero;
        op_valid && ftz && op_denorm |-> result_force_zero && !eff_cause[1];
    endproperty
    a_flush_zero: assert property (p_flush_zero) else $error("flush did not zero"); // see R03

    property p_cause_hold;
        !(clk_en && (op_valid || ctl_wr_en)) |=> $stable(cause);
    endproperty
    a_cause_hold: assert property (p_cause_hold) else $error("cause changed without op"); // see R07

    property p_cause_rewrite;
        clk_en && op_valid |=> cause == $past(eff_cause);
    endproperty
    a_cause_rewrite: assert property (p_cause_rewrite) else $error("cause not rewritten"); // see R07

    property p_no_result;
        op_valid && op_traps |-> !result_wr_en;
    endproperty
    a_no_result: assert property (p_no_result) else $error("trapping op wrote result"); // see R09

    property p_trap_level;
        (|(cause[4:0] & enables)) || cause[5] |-> fp_exc_trap;
    endproperty
    a_trap_level: assert property (p_trap_level) else $error("enabled cause not trapped"); // see R10

    property p_unimpl_traps;
        clk_en && op_valid && op_exc[5] && !ctl_wr_en |=> fp_exc_trap;
    endproperty
    a_unimpl_traps: assert property (p_unimpl_traps) else $error("unimplemented not trapped"); // see R11

    property p_flags_sticky;
        !(clk_en && ctl_wr_en) |=> (flags & $past(flags)) == $past(flags);
    endproperty
    a_flags_sticky: assert property (p_flags_sticky) else $error("flag cleared by op"); // see R14

    property p_trap_keeps_flags;
        s_trap_op and !ctl_wr_en |=> flags == $past(flags);
    endproperty
    a_trap_keeps_flags: assert property (p_trap_keeps_flags) else $error("trap set flags"); // see R15

    property p_quiet_sets_flags;
        s_quiet_op |=> (flags & $past(eff_cause[4:0])) == $past(eff_cause[4:0]);
    endproperty
    a_quiet_sets_flags: assert property (p_quiet_sets_flags) else $error("flag not set"); // see R13

    property p_nearest_tie;
        clk_en && rnd_valid && rm == 2'b00 && rnd_guard && !rnd_sticky
            |=> rnd_increment == $past(rnd_lsb);
    endproperty
    a_nearest_tie: assert property (p_nearest_tie) else $error("tie not to even"); // see R17

    property p_minus_mode;
        clk_en && rnd_valid && rm == 2'b11 && !rnd_sign |=> !rnd_increment;
    endproperty
    a_minus_mode: assert property (p_minus_mode) else $error("rounded up positive"); // see R18

    property p_zero_mode;
        clk_en && rnd_valid && rm == 2'b01 |=> !rnd_increment;
    endproperty
    a_zero_mode: assert property (p_zero_mode) else $error("rounded away from zero"); // see R22

    property p_quiet_writes;
        s_quiet_op |-> result_wr_en;
    endproperty
    a_quiet_writes: assert property (p_quiet_writes) else $error("quiet op blocked"); // see R13

    property p_rename_high;
        rename_out[4:3] == rename_in[4:3];
    endproperty
    a_rename_high: assert property (p_rename_high) else $error("rename upper bits"); // see R04

    property p_cond_read;
        clk_en && ctl_rd_en && hit_cond
            |=> ctl_rdata == {24'h00_0000, $past(view_main[31:25]), $past(view_main[23])};
    endproperty
    a_cond_read: assert property (p_cond_read) else $error("cond alias mismatch"); // see R19

    property p_exc_read;
        clk_en && ctl_rd_en && hit_exc
            |=> ctl_rdata == ($past(view_main) & 32'h0003_f07c);
    endproperty
    a_exc_read: assert property (p_exc_read) else $error("exc alias mismatch"); // see R20

    property p_en_read;
        clk_en && ctl_rd_en && hit_en
            |=> ctl_rdata == {20'h0_0000, $past(view_main[11:7]), 4'h0,
                              $past(view_main[24]), $past(view_main[1:0])};
    endproperty
    a_en_read: assert property (p_en_read) else $error("enable alias mismatch"); // see R21
endmodule : fpcsr_regs

// ===== core/fpcsr_pkg.sv
// Constants for the floating-point control and status register bank
package fpcsr_pkg;
    // Control register numbers on the control-move path
    localparam logic [4:0]  ADDR_COND_ALIAS  = 5'h19;
    localparam logic [4:0]  ADDR_EXC_ALIAS   = 5'h1a;
    localparam logic [4:0]  ADDR_EN_ALIAS    = 5'h1c;
    localparam logic [4:0]  ADDR_CTRL_STATUS = 5'h1f;

    localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_0f80;

    // Main register field positions
    localparam int FCC_HI_MSB   = 31;
    localparam int FCC_HI_LSB   = 25;
    localparam int FTZ_BIT      = 24;
    localparam int FCC0_BIT     = 23;
    localparam int TOP_MODE_BIT = 21;
    localparam int CAUSE_MSB    = 17;
    localparam int CAUSE_LSB    = 12;
    localparam int ENABLE_MSB   = 11;
    localparam int ENABLE_LSB   = 7;
    localparam int FLAG_MSB     = 6;
    localparam int FLAG_LSB     = 2;
    localparam int RM_MSB       = 1;
    localparam int RM_LSB       = 0;

    // Enable alias field positions
    localparam int EN_ALIAS_FTZ_BIT = 2;

    // Bit order inside cause: E V Z O U I
    localparam int EXC_UNIMPL    = 5;
    localparam int EXC_UNDERFLOW = 1;

    typedef enum logic [1:0] {
        FPCSR_RM_NEAREST = 2'b00,
        FPCSR_RM_ZERO    = 2'b01,
        FPCSR_RM_PLUS    = 2'b10,
        FPCSR_RM_MINUS   = 2'b11
    } fpcsr_rm_t;
endpackage : fpcsr_pkg

// ===== core/fpcsr_exc_eval.sv
// Effective cause, flush and trap decision for one completing operation
`timescale 1ns/1ps
module fpcsr_exc_eval (
    input  wire logic [5:0] raw_exc,
    input  wire logic       denorm_result,
    input  wire logic       flush_en,
    input  wire logic [4:0] enables,
    output logic      [5:0] eff_cause,
    output logic            flush_zero,
    output logic            traps
);
    // Flushed denormal gives zero, not underflow
    assign flush_zero = flush_en & denorm_result;  // see R03
    assign eff_cause  = flush_zero
                      ? (raw_exc & ~(6'h01 << fpcsr_pkg::EXC_UNDERFLOW))
                      : raw_exc;  // see R06 see R08
    // Unimplemented has no enable and always traps
    assign traps = (|(eff_cause[4:0] & enables))
                 | eff_cause[fpcsr_pkg::EXC_UNIMPL];  // see R10 see R11
endmodule : fpcsr_exc_eval

// ===== core/fpcsr_round_decide.sv
// Round-up decision from the rounding field and guard bits
`timescale 1ns/1ps
module fpcsr_round_decide (
    input  wire logic [1:0] mode,
    input  wire logic       sign,
    input  wire logic       lsb,
    input  wire logic       guard,
    input  wire logic       sticky,
    output logic            increment
);
    wire inexact = guard | sticky;
    // Magnitude increment per mode
    assign increment =
        (mode == fpcsr_pkg::FPCSR_RM_NEAREST) ? (guard & (sticky | lsb)) :  // see R17
        (mode == fpcsr_pkg::FPCSR_RM_ZERO)    ? 1'b0 :                      // see R22
        (mode == fpcsr_pkg::FPCSR_RM_PLUS)    ? (inexact & ~sign) :         // see R22
                                                (inexact & sign);           // see R18
endmodule : fpcsr_round_decide

// ===== sim/fpcsr_pipe_model.sv
// Pipeline model issuing control moves, compares, operations and rounding queries
`timescale 1ns/1ps
module fpcsr_pipe_model (
    input  wire logic        clk,
    input  wire logic [31:0] ctl_rdata,
    input  wire logic        result_wr_en,
    input  wire logic        result_force_zero,
    output logic             clk_en,
    output logic             ctl_wr_en,
    output logic             ctl_rd_en,
    output logic      [4:0]  ctl_addr,
    output logic      [31:0] ctl_wdata,
    output logic             cmp_valid,
    output logic      [2:0]  cmp_cc_index,
    output logic             cmp_result,
    output logic             op_valid,
    output logic      [5:0]  op_exc,
    output logic             op_denorm,
    output logic             rnd_valid,
    output logic      [3:0]  rnd_bits
);
    initial begin
        {clk_en, ctl_wr_en, ctl_rd_en, cmp_valid, op_valid, rnd_valid} = 6'h01 << 5;
        {ctl_addr, ctl_wdata, cmp_cc_index, cmp_result} = '0;
        {op_exc, op_denorm, rnd_bits} = '0;
    end
    // Strobes rise after one edge and drop after the taking edge
    task automatic ctl_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 ctl_wr_en = 1'b1;
        {ctl_addr, ctl_wdata} = {a, d};
        @(posedge clk);
        #1 ctl_wr_en = 1'b0;
        ctl_wdata = ~d;
    endtask : ctl_write
    task automatic ctl_read(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        #1 ctl_rd_en = 1'b1;
        ctl_addr = a;
        @(posedge clk);
        #1 ctl_rd_en = 1'b0;
        d = ctl_rdata;
    endtask : ctl_read
    task automatic cmp_run(input logic [2:0] i, input logic r);
        @(posedge clk);
        #1 {cmp_valid, cmp_cc_index, cmp_result} = {1'b1, i, r};
        @(posedge clk);
        #1 {cmp_valid, cmp_result} = {1'b0, ~r};
    endtask : cmp_run
    task automatic op_run(input logic [5:0] e, input logic dn, output logic wr, output logic fz);
        @(posedge clk);
        #1 {op_valid, op_exc, op_denorm} = {1'b1, e, dn};
        #1 {wr, fz} = {result_wr_en, result_force_zero};
        @(posedge clk);
        #1 {op_valid, op_exc, op_denorm} = {1'b0, ~e, ~dn};
    endtask : op_run
    task automatic rnd_run(input logic [3:0] b);
        @(posedge clk);
        #1 {rnd_valid, rnd_bits} = {1'b1, b};
        @(posedge clk);
        #1 {rnd_valid, rnd_bits} = {1'b0, ~b};
    endtask : rnd_run
    // Handler clears cause, keeps flags
    task automatic clear_cause(input logic [31:0] v);
        ctl_write(fpcsr_pkg::ADDR_EXC_ALIAS, v & 32'h0000_007c);
    endtask : clear_cause
endmodule : fpcsr_pipe_model

// ===== sim/tb_fpcsr_regs.sv
// Self-checking bench for the control and status register bank
`timescale 1ns/1ps
module tb_fpcsr_regs;
    localparam logic [4:0] AC = fpcsr_pkg::ADDR_COND_ALIAS;
    localparam logic [4:0] AX = fpcsr_pkg::ADDR_EXC_ALIAS;
    localparam logic [4:0] AE = fpcsr_pkg::ADDR_EN_ALIAS;
    localparam logic [4:0] AM = fpcsr_pkg::ADDR_CTRL_STATUS;
    logic        clk, reset_n, clk_en, ctl_wr_en, ctl_rd_en, cmp_valid, cmp_result;
    logic        op_valid, op_denorm, rnd_valid, result_wr_en, result_force_zero;
    logic        fp_exc_trap, rnd_inc_valid, rnd_increment, flush_to_zero, stack_top_mode;
    logic        wr, fz;
    logic [1:0]  rounding_field;
    logic [2:0]  cmp_cc_index, stack_top;
    logic [3:0]  rnd_bits;
    logic [4:0]  ctl_addr, rename_in, rename_out;
    logic [5:0]  op_exc;
    logic [7:0]  fp_condition_codes;
    logic [31:0] ctl_wdata, ctl_rdata, rd;
    int          miscompares = 0;
    int          checks = 0;
    fpcsr_regs dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .ctl_wr_en(ctl_wr_en),
        .ctl_rd_en(ctl_rd_en), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
        .ctl_rdata(ctl_rdata), .cmp_valid(cmp_valid), .cmp_cc_index(cmp_cc_index),
        .cmp_result(cmp_result), .op_valid(op_valid), .op_exc(op_exc),
        .op_denorm(op_denorm), .result_wr_en(result_wr_en),
        .result_force_zero(result_force_zero), .fp_exc_trap(fp_exc_trap),
        .rnd_valid(rnd_valid), .rnd_sign(rnd_bits[3]), .rnd_lsb(rnd_bits[2]),
        .rnd_guard(rnd_bits[1]), .rnd_sticky(rnd_bits[0]), .rnd_inc_valid(rnd_inc_valid),
        .rnd_increment(rnd_increment), .rename_in(rename_in), .stack_top(stack_top),
        .rename_out(rename_out), .rounding_field(rounding_field),
        .flush_to_zero(flush_to_zero), .stack_top_mode(stack_top_mode),
        .fp_condition_codes(fp_condition_codes));
    fpcsr_pipe_model pipe (.clk(clk), .ctl_rdata(ctl_rdata), .result_wr_en(result_wr_en),
        .result_force_zero(result_force_zero), .clk_en(clk_en), .ctl_wr_en(ctl_wr_en),
        .ctl_rd_en(ctl_rd_en), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
        .cmp_valid(cmp_valid), .cmp_cc_index(cmp_cc_index), .cmp_result(cmp_result),
        .op_valid(op_valid), .op_exc(op_exc), .op_denorm(op_denorm),
        .rnd_valid(rnd_valid), .rnd_bits(rnd_bits));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string n);
        pipe.ctl_read(a, rd);
        chk(n, e, rd);
    endtask : rdc
    // Expected increment; c = {sign, lsb, guard, sticky}
    function automatic logic exp_inc(input logic [1:0] m, input logic [3:0] c);
        case (m)
            2'h0: exp_inc = c[1] & (c[0] | c[2]);
            2'h1: exp_inc = 1'b0;
            2'h2: exp_inc = ~c[3] & (c[1] | c[0]);
            default: exp_inc = c[3] & (c[1] | c[0]);
        endcase
    endfunction : exp_inc
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    initial begin
        #(100 * 3000);
        miscompares++;
        close_out();
    end
    initial begin
        reset_n = 1'b0;
        stack_top = 3'h6;
        rename_in = 5'h1d;
        repeat (10) @(posedge clk);
        #1 reset_n = 1'b1;
        rdc(AM, 32'h0000_0f80, "main_reset");
        rdc(AE, 32'h0000_0f80, "en_alias_reset");
        rdc(AX, 32'h0000_0000, "exc_alias_reset");
        rdc(5'h05, 32'h0000_0000, "unmapped");
        pipe.cmp_run(3'h0, 1'b1);
        pipe.cmp_run(3'h3, 1'b1);
        chk("cc_out", 32'h0000_0009, 32'(fp_condition_codes));
        rdc(AM, 32'h0880_0f80, "main_cc");
        rdc(AC, 32'h0000_0009, "cc_alias");
        pipe.cmp_run(3'h0, 1'b0);
        pipe.ctl_write(AC, 32'h0000_0002);
        rdc(AM, 32'h0200_0f80, "cc_write");
        pipe.ctl_write(AM, 32'h0000_0000);
        pipe.op_run(6'h15, 1'b0, wr, fz);
        chk("wr_untrapped", 32'h0000_0001, 32'(wr));
        rdc(AX, 32'h0001_5054, "multi_cause");
        pipe.ctl_write(AE, 32'h0000_0200);
        chk("trap_by_write", 32'h0000_0001, 32'(fp_exc_trap));
        rdc(AM, 32'h0001_5254, "move_keeps_cause");
        pipe.clear_cause(32'h0001_5054);
        chk("trap_cleared", 32'h0000_0000, 32'(fp_exc_trap));
        pipe.op_run(6'h01, 1'b0, wr, fz);
        rdc(AX, 32'h0000_1054, "cause_rewrite");
        pipe.ctl_write(AX, 32'h0000_0000);
        pipe.ctl_write(AE, 32'h0000_0800);
        pipe.op_run(6'h10, 1'b0, wr, fz);
        chk("wr_trapped", 32'h0000_0000, 32'(wr));
        chk("trap_op", 32'h0000_0001, 32'(fp_exc_trap));
        rdc(AX, 32'h0001_0000, "flags_kept");
        pipe.clear_cause(32'h0001_0000);
        pipe.ctl_write(AE, 32'h0000_0000);
        pipe.op_run(6'h20, 1'b0, wr, fz);
        chk("trap_unimpl", 32'h0000_0001, 32'(fp_exc_trap));
        rdc(AX, 32'h0002_0000, "unimpl_cause");
        pipe.clear_cause(32'h0002_0000);
        pipe.ctl_write(AE, 32'h0000_0104);
        pipe.op_run(6'h02, 1'b1, wr, fz);
        chk("flush_zero", 32'h0000_000d, 32'({wr, fz, fp_exc_trap, flush_to_zero}));
        pipe.ctl_write(AM, 32'h0020_0000);
        chk("top_mode", 32'h0000_0001, 32'(stack_top_mode));
        chk("rename_on", 32'h0000_001b, 32'(rename_out));
        pipe.ctl_write(AM, 32'h0000_0000);
        chk("rename_off", 32'h0000_001d, 32'(rename_out));
        for (int m = 0; m < 4; m++) begin
            pipe.ctl_write(AE, 32'(m));
            chk("rm_out", 32'(m), 32'(rounding_field));
            for (int c = 0; c < 16; c++) begin
                pipe.rnd_run(c[3:0]);
                chk("rnd_inc", 32'({1'b1, exp_inc(m[1:0], c[3:0])}),
                    32'({rnd_inc_valid, rnd_increment}));
            end
        end
        close_out();
    end
endmodule : tb_fpcsr_regs
